// ==== hdl/pros_cfg_if.sv ====
`timescale 1ns/10ps
interface pros_cfg_if;
  import pros_pkg::*;
  logic [CODE_W-1:0] code;
  logic [FREQ_W-1:0] fsup;
  logic [FREQ_W-1:0] hyst;
  modport src (output code, output fsup, input hyst);
  modport snk (input code, input fsup, output hyst);
endinterface

// ==== hdl/pros_hyst.sv ====
`timescale 1ns/10ps
module pros_hyst
  import pros_pkg::*;
(
  pros_cfg_if.snk cfg
);
  logic [FREQ_W+2:0] pct;
  always_comb begin
    pct = ({3'b000, cfg.fsup} * HYST_PCT) / PCT_DIV;
    if (cfg.fsup > HYST_KNEE) begin
      cfg.hyst = HYST_FIXED;
    end else begin
      cfg.hyst = pct[FREQ_W-1:0];
    end
  end
endmodule

// ==== hdl/pros_pkg.sv ====
// Contract
// - each relay has its own function code, one of eleven, 1 through 11
// - reset defaults: relay one fault function, relay two code 7 running
// - code 1 releases relay on fault; fault indicator lit together
// - code 2 energizes after initialization, immediately upon selection
// - code 3 energizes above current limit, holds at least 250 ms
// - code 4 releases above limit, re-energizes below limit minus hysteresis
// - code 5 releases below limit, re-energizes above limit plus hysteresis
// - hysteresis 2 Hz above 10 Hz limit, otherwise 20 % of limit
// - code 6 releases while modulator reports running forward
// - code 7 energizes while modulator reports running
// - code 8 releases while motor overtemperature fault is active
// - code 9 releases while under local panel control
// - code 10 always releases, immediately
// - code 11 energizes while any fault active; fault indicator lit; relay and indicator follow fault_i only, not otemp_fault_i
package pros_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MIN_ON_MS     = 250;
  localparam int unsigned MIN_ON_CYC    = CLK_HZ / 1000 * MIN_ON_MS;
  localparam int unsigned FREQ_W        = 16;   // frequency in 0.1 Hz units
  localparam int unsigned CODE_W        = 4;
  localparam int unsigned TMR_W         = 25;
  localparam logic [FREQ_W-1:0] HYST_FIXED  = 16'h0014;  // 2 Hz
  localparam logic [FREQ_W-1:0] HYST_KNEE   = 16'h0064;  // 10 Hz
  localparam logic [FREQ_W+2:0] HYST_PCT    = 19'h00014; // 20 %
  localparam logic [FREQ_W+2:0] PCT_DIV     = 19'h00064; // 100
  localparam logic [CODE_W-1:0] CODE_FAULT  = 4'h1;
  localparam logic [CODE_W-1:0] CODE_POWER  = 4'h2;
  localparam logic [CODE_W-1:0] CODE_ILIM   = 4'h3;
  localparam logic [CODE_W-1:0] CODE_FHIGH  = 4'h4;
  localparam logic [CODE_W-1:0] CODE_FLOW   = 4'h5;
  localparam logic [CODE_W-1:0] CODE_FWD    = 4'h6;
  localparam logic [CODE_W-1:0] CODE_RUN    = 4'h7;
  localparam logic [CODE_W-1:0] CODE_OTEMP  = 4'h8;
  localparam logic [CODE_W-1:0] CODE_LOCAL  = 4'h9;
  localparam logic [CODE_W-1:0] CODE_NONE   = 4'hA;
  localparam logic [CODE_W-1:0] CODE_FAULTN = 4'hB;
  localparam logic [CODE_W-1:0] RST_CODE1   = CODE_FAULT;
  localparam logic [CODE_W-1:0] RST_CODE2   = CODE_RUN;
  localparam int unsigned NUM_EVT         = 4;
  localparam int unsigned EVT_FAULT       = 0;
  localparam int unsigned EVT_ILIM        = 1;
  localparam int unsigned EVT_OTEMP       = 2;
  localparam int unsigned EVT_BADCODE     = 3;
  localparam logic [3:0] ADR_CODE1  = 4'h0;
  localparam logic [3:0] ADR_CODE2  = 4'h1;
  localparam logic [3:0] ADR_FSUP   = 4'h2;
  localparam logic [3:0] ADR_STAT   = 4'h3;
  localparam logic [3:0] ADR_IRQ    = 4'h4;
  localparam logic [3:0] ADR_MASK   = 4'h5;
  localparam logic [FREQ_W-1:0] RST_FSUP = 16'h0000;
  typedef enum logic [1:0] {PROS_IDLE = 2'b00, PROS_ACK = 2'b01} pros_bus_e;
endpackage

// ==== hdl/pros_relay_ch.sv ====
`timescale 1ns/10ps
module pros_relay_ch
  import pros_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              init_done_i,
  input  wire logic              fault_i,
  input  wire logic              otemp_i,
  input  wire logic              over_ilim_i,
  input  wire logic [FREQ_W-1:0] out_freq_i,
  input  wire logic              run_i,
  input  wire logic              fwd_i,
  input  wire logic              local_i,
  pros_cfg_if.src                cfg,
  input  wire logic [CODE_W-1:0] code_i,
  input  wire logic [FREQ_W-1:0] fsup_i,
  output logic                   relay_o,
  output logic                   ilim_ind_o
);
  import pros_pkg::*;
  logic [TMR_W-1:0] tmr_q;
  logic             fhi_q;
  logic             flo_q;
  logic             rel_d;
  logic [FREQ_W:0]  up_lim;
  logic [FREQ_W:0]  dn_lim;

  assign cfg.code = code_i;
  assign cfg.fsup = fsup_i;
  assign up_lim = {1'b0, fsup_i} + {1'b0, cfg.hyst};
  assign dn_lim = {1'b0, fsup_i} - {1'b0, cfg.hyst};

  // -------------------------------------------------------------------
  // current limit minimum-on timer
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_q <= '0;
    end else if (over_ilim_i) begin
      tmr_q <= TMR_W'(MIN_ON_CYC);
    end else if (tmr_q != '0) begin
      tmr_q <= tmr_q - 1'b1;
    end
  end
  assign ilim_ind_o = over_ilim_i || (tmr_q != '0);

  // -------------------------------------------------------------------
  // frequency supervision hysteresis latches
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fhi_q <= 1'b1;
      flo_q <= 1'b0;
    end else begin
      if (out_freq_i > fsup_i) begin
        fhi_q <= 1'b0;
      end else if ({1'b0, out_freq_i} < dn_lim && dn_lim[FREQ_W] == 1'b0) begin
        fhi_q <= 1'b1;
      end
      if (out_freq_i < fsup_i) begin
        flo_q <= 1'b0;
      end else if ({1'b0, out_freq_i} > up_lim) begin
        flo_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rel_d = 1'b0;
    unique case (code_i)
      CODE_FAULT:  rel_d = !fault_i;
      CODE_POWER:  rel_d = 1'b1;
      CODE_ILIM:   rel_d = ilim_ind_o;
      CODE_FHIGH:  rel_d = fhi_q;
      CODE_FLOW:   rel_d = flo_q;
      CODE_FWD:    rel_d = !(run_i && fwd_i);
      CODE_RUN:    rel_d = run_i;
      CODE_OTEMP:  rel_d = !otemp_i;
      CODE_LOCAL:  rel_d = !local_i;
      CODE_NONE:   rel_d = 1'b0;
      CODE_FAULTN: rel_d = fault_i;
      default:     rel_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      relay_o <= 1'b0;
    end else begin
      relay_o <= init_done_i && rel_d;
    end
  end

  a_none_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_NONE |=> !relay_o)
    else $error("relay energized with code none");
  a_power_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_POWER && init_done_i |=> relay_o)
    else $error("power code relay not energized");
  a_ilim_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_ILIM && $fell(over_ilim_i) ##1 (code_i == CODE_ILIM && init_done_i)[*8]
    |-> relay_o)
    else $error("current limit relay dropped early");
  a_fault_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_FAULT && fault_i |=> !relay_o)
    else $error("fault code relay still energized");
  a_run_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_RUN && init_done_i |=> relay_o == $past(run_i))
    else $error("run relay does not follow modulator");
  a_fwd_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_FWD && run_i && fwd_i |=> !relay_o)
    else $error("forward relay energized");
  a_otemp_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_OTEMP && otemp_i |=> !relay_o)
    else $error("overtemperature relay energized");
  a_local_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_LOCAL && init_done_i |=> relay_o == !$past(local_i))
    else $error("local relay wrong");
  a_faultn_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_FAULTN && init_done_i |=> relay_o == $past(fault_i))
    else $error("inverted fault relay wrong");
  a_fhigh_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_FHIGH && out_freq_i > fsup_i ##1 code_i == CODE_FHIGH |=> !relay_o)
    else $error("high frequency relay energized");
  a_flow_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    code_i == CODE_FLOW && out_freq_i < fsup_i ##1 code_i == CODE_FLOW |=> !relay_o)
    else $error("low frequency relay energized");
  a_init_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !init_done_i |=> !relay_o)
    else $error("relay energized before init");
endmodule

// ==== hdl/pros_relay_top.sv ====
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module pros_relay_top
  import pros_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic              init_done_i,
  input  wire logic              fault_i,
  input  wire logic              otemp_fault_i,
  input  wire logic              over_ilim_i,
  input  wire logic [FREQ_W-1:0] out_freq_i,
  input  wire logic              mod_run_i,
  input  wire logic              mod_fwd_i,
  input  wire logic              local_ctrl_i,
  input  wire logic [3:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   relay1_o,
  output logic                   relay2_o,
  output logic                   fault_led_o,
  output logic                   irq_o
);
  import pros_pkg::*;
  logic              rst_s1_q;
  logic              rst_n_q;
  logic [CODE_W-1:0] code1_q;
  logic [CODE_W-1:0] code2_q;
  logic [FREQ_W-1:0] fsup_q;
  logic [NUM_EVT-1:0] stat_q;
  logic [NUM_EVT-1:0] mask_q;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] evt_lvl;
  logic [NUM_EVT-1:0] evt_prev_q;
  logic              r1;
  logic              r2;
  logic              il1;
  logic              il2;
  logic              acc;
  logic              wr_acc;
  pros_bus_e         bus_q;
  pros_cfg_if        cfg1 ();
  pros_cfg_if        cfg2 ();

  function automatic logic code_ok(input logic [CODE_W-1:0] c);
    code_ok = (c >= CODE_FAULT) && (c <= CODE_FAULTN);
  endfunction

  // -------------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // -------------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // -------------------------------------------------------------------
  assign acc    = (avs_read_i || avs_write_i) && bus_q == PROS_IDLE;
  assign wr_acc = avs_write_i && bus_q == PROS_ACK;

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_q             <= PROS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_q             <= acc ? PROS_ACK : PROS_IDLE;
      avs_waitrequest_o <= !acc;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      code1_q <= RST_CODE1;
      code2_q <= RST_CODE2;
      fsup_q  <= RST_FSUP;
      mask_q  <= '0;
    end else if (wr_acc) begin
      unique case (avs_address_i)
        ADR_CODE1: begin
          if (code_ok(avs_writedata_i[CODE_W-1:0])) begin
            code1_q <= avs_writedata_i[CODE_W-1:0];
          end
        end
        ADR_CODE2: begin
          if (code_ok(avs_writedata_i[CODE_W-1:0])) begin
            code2_q <= avs_writedata_i[CODE_W-1:0];
          end
        end
        ADR_FSUP:  fsup_q <= avs_writedata_i[FREQ_W-1:0];
        ADR_MASK:  mask_q <= avs_writedata_i[NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata_o <= '0;
    end else if (acc && avs_read_i) begin
      unique case (avs_address_i)
        ADR_CODE1: avs_readdata_o <= {28'h0000000, code1_q};
        ADR_CODE2: avs_readdata_o <= {28'h0000000, code2_q};
        ADR_FSUP:  avs_readdata_o <= {16'h0000, fsup_q};
        ADR_STAT:  avs_readdata_o <= {26'h0, il2, il1, fault_led_o, relay2_o, relay1_o,
                                      otemp_fault_i};
        ADR_IRQ:   avs_readdata_o <= {28'h0000000, stat_q};
        ADR_MASK:  avs_readdata_o <= {28'h0000000, mask_q};
        default:   avs_readdata_o <= '0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // interrupt events: rising edges, write one to clear, set wins
  // -------------------------------------------------------------------
  assign evt_lvl = {wr_acc && (avs_address_i == ADR_CODE1 || avs_address_i == ADR_CODE2)
                    && !code_ok(avs_writedata_i[CODE_W-1:0]),
                    otemp_fault_i, over_ilim_i, fault_i};
  assign evt = evt_lvl & ~evt_prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_prev_q <= '0;
      stat_q     <= '0;
      irq_o      <= 1'b0;
    end else begin
      evt_prev_q <= {1'b0, evt_lvl[NUM_EVT-2:0]};
      if (wr_acc && avs_address_i == ADR_IRQ) begin
        stat_q <= (stat_q & ~avs_writedata_i[NUM_EVT-1:0]) | evt;
      end else begin
        stat_q <= stat_q | evt;
      end
      // a mask bit set lets its status bit reach the interrupt
      irq_o <= |(stat_q & mask_q);
    end
  end

  // -------------------------------------------------------------------
  // relay channels
  // -------------------------------------------------------------------
  pros_hyst u_hyst1 (.cfg(cfg1.snk));
  pros_hyst u_hyst2 (.cfg(cfg2.snk));

  pros_relay_ch u_ch1 (
    .clk_i       (clk_sys_i),
    .rst_n_i     (rst_n_q),
    .init_done_i (init_done_i),
    .fault_i     (fault_i),
    .otemp_i     (otemp_fault_i),
    .over_ilim_i (over_ilim_i),
    .out_freq_i  (out_freq_i),
    .run_i       (mod_run_i),
    .fwd_i       (mod_fwd_i),
    .local_i     (local_ctrl_i),
    .cfg         (cfg1.src),
    .code_i      (code1_q),
    .fsup_i      (fsup_q),
    .relay_o     (r1),
    .ilim_ind_o  (il1)
  );

  pros_relay_ch u_ch2 (
    .clk_i       (clk_sys_i),
    .rst_n_i     (rst_n_q),
    .init_done_i (init_done_i),
    .fault_i     (fault_i),
    .otemp_i     (otemp_fault_i),
    .over_ilim_i (over_ilim_i),
    .out_freq_i  (out_freq_i),
    .run_i       (mod_run_i),
    .fwd_i       (mod_fwd_i),
    .local_i     (local_ctrl_i),
    .cfg         (cfg2.src),
    .code_i      (code2_q),
    .fsup_i      (fsup_q),
    .relay_o     (r2),
    .ilim_ind_o  (il2)
  );

  assign relay1_o = r1;
  assign relay2_o = r2;

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_led_o <= 1'b0;
    end else begin
      fault_led_o <= fault_i;
    end
  end

  a_fault_led: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
    fault_i |=> fault_led_o)
    else $error("fault indicator not lit");
  a_code_default: assert property (@(posedge clk_sys_i)
    $rose(rst_n_q) |-> code1_q == CODE_FAULT && code2_q == CODE_RUN)
    else $error("reset codes wrong");
  a_code_legal: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
    code_ok(code1_q) && code_ok(code2_q))
    else $error("illegal function code held");
endmodule

// ==== verification/pros_relay_coil.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// relay coil with contact pickup delay
// ----------------------------------------
module pros_relay_coil #(
  parameter int PICKUP = 2
) (
  input  wire logic clk_i,
  input  wire logic coil_i,
  output logic      contact_o
);
  int held = 0;

  // contact closes after the coil has been held, drops out at once
  always @(posedge clk_i) begin
    if (!coil_i) begin
      held <= 0;
    end else if (held < PICKUP) begin
      held <= held + 1;
    end
  end

  assign contact_o = coil_i && (held >= PICKUP);
endmodule

// ==== verification/test_programmable_relay_output_selector.sv ====
`timescale 1ns/10ps
module test_programmable_relay_output_selector;
  import pros_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              clk;
  logic              reset_n;
  logic              init_done;
  logic [4:0]        vin;
  logic              ilim;
  logic [FREQ_W-1:0] freq;
  logic [3:0]        addr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              wait_req;
  logic              relay1;
  logic              relay2;
  logic              fled;
  logic              irq;
  logic              contact1;
  logic              contact2;
  logic [31:0]       q;
  logic [3:0]        codes [8] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
  int                fail_count;
  int                checked;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // vin packs {fault, otemp, run, fwd, local}
  pros_relay_top DUT (
    .clk_sys_i         (clk),
    .reset_n_i         (reset_n),
    .init_done_i       (init_done),
    .fault_i           (vin[4]),
    .otemp_fault_i     (vin[3]),
    .over_ilim_i       (ilim),
    .out_freq_i        (freq),
    .mod_run_i         (vin[2]),
    .mod_fwd_i         (vin[1]),
    .local_ctrl_i      (vin[0]),
    .avs_address_i     (addr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wdata),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (wait_req),
    .relay1_o          (relay1),
    .relay2_o          (relay2),
    .fault_led_o       (fled),
    .irq_o             (irq)
  );

  pros_relay_coil #(.PICKUP(0)) coil1 (.clk_i(clk), .coil_i(relay1), .contact_o(contact1));
  pros_relay_coil #(.PICKUP(3)) coil2 (.clk_i(clk), .coil_i(relay2), .contact_o(contact2));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // avalon access: hold request until waitrequest sampled low
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    forever begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic freq_step(input logic [FREQ_W-1:0] f, input logic e);
    freq <= f;
    tick(3);
    chk("relay1 freq", {31'h0, relay1}, {31'h0, e});
  endtask

  function automatic logic fexp(input logic [3:0] c, input logic [4:0] v);
    case (c)
      CODE_FAULT:  fexp = ~v[4];
      CODE_POWER:  fexp = 1'b1;
      CODE_FWD:    fexp = ~(v[2] & v[1]);
      CODE_RUN:    fexp = v[2];
      CODE_OTEMP:  fexp = ~v[3];
      CODE_LOCAL:  fexp = ~v[0];
      CODE_FAULTN: fexp = v[4];
      default:     fexp = 1'b0;
    endcase
  endfunction

  task automatic summarize();
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    init_done = 1'b0;
    vin = 5'h00;
    ilim = 1'b0;
    freq = 16'h0000;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    fail_count = 0;
    checked = 0;
    tick(4);
    reset_n <= 1'b1;
    tick(4);
    access(1'b0, ADR_CODE1, 32'h0);
    chk("code1 reset", q, 32'h1);
    access(1'b0, ADR_CODE2, 32'h0);
    chk("code2 reset", q, 32'h7);
    access(1'b1, ADR_CODE1, {28'h0, CODE_POWER});
    tick(3);
    chk("relay1 before init", {31'h0, relay1}, 32'h0);
    init_done <= 1'b1;
    tick(3);
    chk("relay1 after init", {31'h0, relay1}, 32'h1);
    // every plain function against every input combination
    for (int i = 0; i < 8; i++) begin
      access(1'b1, ADR_CODE1, {28'h0, codes[i]});
      access(1'b1, ADR_CODE2, {28'h0, codes[i]});
      for (int v = 0; v < 32; v++) begin
        vin <= v[4:0];
        tick(3);
        chk("relay1", {31'h0, relay1}, {31'h0, fexp(codes[i], v[4:0])});
        chk("relay2", {31'h0, relay2}, {31'h0, fexp(codes[i], v[4:0])});
        chk("fault_led", {31'h0, fled}, {31'h0, v[4]});
      end
    end
    vin <= 5'h00;
    access(1'b1, ADR_CODE1, {28'h0, CODE_POWER});
    access(1'b1, ADR_CODE2, {28'h0, CODE_POWER});
    access(1'b1, ADR_CODE1, {28'h0, CODE_NONE});
    tick(2);
    chk("relay1 released", {31'h0, relay1}, 32'h0);
    chk("relay2 kept", {31'h0, relay2}, 32'h1);
    tick(4);
    chk("slow contact2", {31'h0, contact2}, 32'h1);
    chk("contact1 open", {31'h0, contact1}, 32'h0);
    // current limit with minimum on time
    access(1'b1, ADR_CODE1, {28'h0, CODE_ILIM});
    ilim <= 1'b1;
    tick(3);
    chk("relay1 ilim", {31'h0, relay1}, 32'h1);
    ilim <= 1'b0;
    repeat (8) begin
      tick(1);
      chk("relay1 ilim hold", {31'h0, relay1}, 32'h1);
    end
    access(1'b0, ADR_STAT, 32'h0);
    chk("status ilim", q, 32'h36);
    // supervision limit 50 Hz above knee, then 5 Hz below
    access(1'b1, ADR_FSUP, 32'h1F4);
    access(1'b1, ADR_CODE1, {28'h0, CODE_FHIGH});
    freq_step(16'h0000, 1'b1);
    freq_step(16'h01F5, 1'b0);
    freq_step(16'h01E1, 1'b0);
    freq_step(16'h01DF, 1'b1);
    freq_step(16'h01F3, 1'b1);
    access(1'b1, ADR_FSUP, 32'h32);
    access(1'b1, ADR_CODE1, {28'h0, CODE_FLOW});
    freq_step(16'h0064, 1'b1);
    freq_step(16'h0031, 1'b0);
    freq_step(16'h003B, 1'b0);
    freq_step(16'h003D, 1'b1);
    freq_step(16'h0033, 1'b1);
    // interrupts, refused code and unmapped read
    freq <= 16'h0000;
    access(1'b1, ADR_MASK, 32'h0);
    access(1'b1, ADR_IRQ, 32'hF);
    tick(3);
    chk("irq idle", {31'h0, irq}, 32'h0);
    access(1'b1, ADR_CODE1, 32'hC);
    tick(3);
    access(1'b0, ADR_CODE1, 32'h0);
    chk("code1 kept", q, {28'h0, CODE_FLOW});
    access(1'b0, ADR_IRQ, 32'h0);
    chk("irq badcode", q, 32'h8);
    chk("irq masked", {31'h0, irq}, 32'h0);
    access(1'b1, ADR_MASK, 32'h8);
    tick(3);
    chk("irq raised", {31'h0, irq}, 32'h1);
    access(1'b1, ADR_IRQ, 32'h8);
    tick(3);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    access(1'b1, ADR_MASK, 32'h1);
    vin <= 5'h10;
    tick(3);
    chk("irq fault", {31'h0, irq}, 32'h1);
    access(1'b0, ADR_IRQ, 32'h0);
    chk("irq status", q, 32'h1);
    access(1'b0, 4'hF, 32'h0);
    chk("unmapped", q, 32'h0);
    summarize();
  end
endmodule
